// ===== rtl/bdu_defines.svh
// Constants of the branch decision unit: opcodes, field positions, lengths.
// Operation
// - Unconditional branch replaces sequential address unless the register form has a zero second field
// - Condition code held in status bits 34-35
// - Code-setting operations overwrite code; others keep it
// - Saved status and link word carry condition code
// - New code only from code-setting operation, status load or interruption
// - Branches never alter code; execute subject decides
// - Zero second register field suppresses register branch
// - Indexed target is index plus base plus displacement
// - Storage form: base plus displacement; third operand odd
// - Target first, then arithmetic or link, then replace
// - Only the first-field register receives results
// - Register target is low 24 bits of register
// - Mask bits 8,4,2,1 test codes 0 to 3
// - Mask 15 branches unless the register form has a zero second field; mask 0 never does
// - Link writes right status half then branches
// - Link target resolved before link word written
// - Link word: length, code, mask, updated address
// - Link with zero target field links, no branch
// - Link under execute records length code 2
// - Count decrements; branches only when result nonzero
// - Decrement is 32-bit wrapping, code untouched
// - Last-location branch to valid address raises nothing
// - Register count with zero target never branches
// - Odd fetch address raises specification exception
// - Bad targets are caught at next fetch only
`ifndef BDU_DEFINES_SVH
`define BDU_DEFINES_SVH

`define BDU_OP_LINK_RR   8'h05
`define BDU_OP_COUNT_RR  8'h06
`define BDU_OP_COND_RR   8'h07
`define BDU_OP_LINK_RX   8'h45
`define BDU_OP_COUNT_RX  8'h46
`define BDU_OP_COND_RX   8'h47
`define BDU_OP_IDX_HIGH  8'h86
`define BDU_OP_IDX_LOW   8'h87

`define BDU_ILC_RR       2'h1
`define BDU_ILC_RX       2'h2
`define BDU_ILC_EXEC     2'h2
`define BDU_CC_MSB       34
`define BDU_CC_LSB       35
`define BDU_ADDR_W       24
`define BDU_REG_COUNT    16

`endif

// ===== rtl/bdu_pkg.sv
// Types of the branch decision unit.
package bdu_pkg;

   // Sequencing phases of one branching instruction.
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_ADDR,
      PH_EXEC,
      PH_REPL
   } bdu_phase_t;

   // One decoded instruction as handed over by the fetch sequencer.
   typedef struct packed {
      logic [7:0]  opcode;                 // Operation code.
      logic [3:0]  first_register_field;   // Also the branch mask field.
      logic [3:0]  second_register_field;  // Also index or third register field.
      logic [3:0]  base_register_field;    // Base register field.
      logic [11:0] displacement_field;     // Displacement.
      logic        execute_subject_instr;  // Issued as subject of execute.
      logic [1:0]  ilc;                    // Instruction-length code.
   } bdu_req_t;

   // Rightmost half of the status word.
   typedef struct packed {
      logic [1:0]  ilc;                    // Instruction-length code.
      logic [1:0]  cc;                     // Condition code.
      logic [3:0]  pmask;                  // Program mask.
      logic [23:0] ia;                     // Instruction address.
   } bdu_psw_t;

   // Whole state of the unit.
   typedef struct packed {
      bdu_phase_t       phase;             // Sequencing phase.
      bdu_req_t         req;               // Latched instruction.
      bdu_psw_t         program_status_word;               // Status word right half.
      logic [15:0][31:0] gpr;              // General registers.
      logic [23:0]      tgt;               // Latched branch target.
      logic [23:0]      upd;               // Updated sequential address.
      logic             take;              // Branch successful.
      logic             done;              // Completion pulse.
      logic [3:0]       odd_idx;           // Third-operand register.
      logic [31:0]      rd_data;           // Register readback.
      logic             spec_exc;          // Odd fetch address.
      logic             addr_exc;          // Unavailable fetch address.
      logic             busy;              // Instruction in progress, registered.
   } bdu_state_t;

endpackage

// ===== rtl/bdu_top.sv
// Branch decision, target formation, link and count logic of the instruction unit.
`timescale 1ns/10ps
`include "bdu_defines.svh"

module bdu_top (
   input  wire logic            clk,          // Processor clock, 20 MHz.
   input  wire logic            rstn,         // Asynchronous reset, active low.
   input  wire logic            start,        // Issue one branching instruction.
   input  wire bdu_pkg::bdu_req_t req,        // Decoded instruction fields.
   input  wire logic            psw_load,     // Status load, mask set or interruption.
   input  wire bdu_pkg::bdu_psw_t psw_new,    // Status half loaded by psw_load.
   input  wire logic            cc_set_en,    // Another operation sets the code.
   input  wire logic [1:0]      cc_set_val,   // Code produced by that operation.
   input  wire logic            gr_wr_en,     // External general register write.
   input  wire logic [3:0]      gr_wr_idx,    // Register written.
   input  wire logic [31:0]     gr_wr_data,   // Data written.
   input  wire logic [3:0]      gr_rd_idx,    // Register read back.
   input  wire logic            fetch_req,    // Sequencer fetches at current address.
   input  wire logic [23:0]     storage_top,  // Highest available byte address.
   output logic [31:0]          gr_rd_data,   // Registered readback.
   output bdu_pkg::bdu_psw_t    program_status_word,          // Right half of status word.
   output logic [23:0]          target,       // Last computed branch target.
   output logic [3:0]           odd_operand,  // Third-operand register index.
   output logic                 busy,         // Instruction in progress.
   output logic                 done,         // One-cycle completion pulse.
   output logic                 taken,        // Last branch was successful.
   output logic                 spec_exc,     // Specification exception pulse.
   output logic                 addr_exc      // Addressing exception pulse.
);

   bdu_pkg::bdu_state_t s;        // Registered state.
   bdu_pkg::bdu_state_t next_s;   // Next state.

   // Format and class decode of the latched opcode.
   logic        is_rr;            // Register-register format.
   logic        is_rs;            // Register-storage format.
   logic        is_cond;          // Conditional branch.
   logic        is_link;          // Branch and link.
   logic        is_count;         // Branch on count.
   logic [31:0] idx_val;          // Index component.
   logic [31:0] base_val;         // Base component.
   logic [31:0] dec_val;          // Decremented count.
   logic [1:0]  ilc_eff;          // Length code recorded in link word.
   logic [3:0]  f1;               // First field shorthand.
   logic [3:0]  f2;               // Second field shorthand.

   always_comb begin
      f1       = s.req.first_register_field;
      f2       = s.req.second_register_field;
      is_rr    = (s.req.opcode[7:4] == 4'h0);
      is_rs    = (s.req.opcode == `BDU_OP_IDX_HIGH) || (s.req.opcode == `BDU_OP_IDX_LOW);
      is_cond  = (s.req.opcode == `BDU_OP_COND_RR) || (s.req.opcode == `BDU_OP_COND_RX);
      is_link  = (s.req.opcode == `BDU_OP_LINK_RR) || (s.req.opcode == `BDU_OP_LINK_RX);
      is_count = (s.req.opcode == `BDU_OP_COUNT_RR) || (s.req.opcode == `BDU_OP_COUNT_RX);
      // A zero index or base field adds nothing, whatever register 0 holds.
      idx_val  = (!is_rs && f2 != 4'h0) ? s.gpr[f2] : 32'h0000_0000;
      base_val = (s.req.base_register_field != 4'h0) ? s.gpr[s.req.base_register_field] : 32'h0000_0000;
      // Two's-complement wrap from most negative to most positive is ignored.
      dec_val  = s.gpr[f1] - 32'h0000_0001;
      // Under execute the length of the execute instruction is recorded.
      ilc_eff  = s.req.execute_subject_instr ? `BDU_ILC_EXEC : s.req.ilc;
   end

   // Next-state logic: the whole sequence is one state record.
   always_comb begin
      next_s          = s;
      next_s.done     = 1'b0;
      next_s.rd_data  = s.gpr[gr_rd_idx];
      // Faults of an odd or unavailable address show only at fetch, never at the branch.
      next_s.spec_exc = fetch_req && s.program_status_word.ia[0];
      // A branch that leaves the last location for a valid target never fetches beyond it.
      next_s.addr_exc = fetch_req && !s.program_status_word.ia[0] && (s.program_status_word.ia > storage_top);
      if (gr_wr_en && s.phase == bdu_pkg::PH_IDLE) begin
         next_s.gpr[gr_wr_idx] = gr_wr_data;
      end
      case (s.phase)
         // Wait for an instruction; the updated address is formed in the address phase.
         bdu_pkg::PH_IDLE: begin
            if (start && !psw_load) begin
               next_s.req   = req;
               next_s.take  = 1'b0;
               next_s.phase = bdu_pkg::PH_ADDR;
            end
         end
         // Address computation uses original register contents only.
         bdu_pkg::PH_ADDR: begin
            // Sequential address is ready before the decision is made.
            next_s.upd = s.program_status_word.ia + {21'h000000, ilc_eff, 1'b0};
            if (is_rr) begin
               next_s.tgt = s.gpr[f2][23:0];
            end else begin
               next_s.tgt = idx_val[23:0] + base_val[23:0] + {12'h000, s.req.displacement_field};
            end
            // Odd register always holds the third operand.
            next_s.odd_idx = f2 | 4'h1;
            if (is_cond) begin
               // Mask bit 8 tests code 0, bit 1 tests code 3.
               next_s.take = s.req.first_register_field[2'h3 - s.program_status_word.cc] && !(is_rr && f2 == 4'h0);
            end else if (is_link) begin
               next_s.take = !(is_rr && f2 == 4'h0);
            end
            next_s.phase = bdu_pkg::PH_EXEC;
         end
         // Arithmetic or link storage, always into the first-field register.
         bdu_pkg::PH_EXEC: begin
            if (is_link) begin
               // Link word carries length, code, mask and updated address.
               next_s.gpr[f1] = {ilc_eff, s.program_status_word.cc, s.program_status_word.pmask, s.upd};
            end else if (is_count) begin
               next_s.gpr[f1] = dec_val;
               next_s.take    = (dec_val != 32'h0000_0000) && !(is_rr && f2 == 4'h0);
            end
            next_s.phase = bdu_pkg::PH_REPL;
         end
         // Replace the instruction address with the target found earlier if taken, else with the updated address.
         bdu_pkg::PH_REPL: begin
            next_s.program_status_word.ia = s.take ? s.tgt : s.upd;
            next_s.done   = 1'b1;
            next_s.phase  = bdu_pkg::PH_IDLE;
         end
         default: begin
            next_s.phase = bdu_pkg::PH_IDLE;
         end
      endcase
      // Code changes only by status load or a code-setting operation, never by a branch.
      if (psw_load) begin
         next_s.program_status_word = psw_new;
      end else if (cc_set_en) begin
         next_s.program_status_word.cc = cc_set_val;
      end
      // Busy is kept in its own flop so the output has no decode behind it.
      next_s.busy = (next_s.phase != bdu_pkg::PH_IDLE);
   end

   // State register; reset clears all state to constants.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Outputs come straight from the state flops.
   assign gr_rd_data  = s.rd_data;
   assign program_status_word         = s.program_status_word;
   assign target      = s.tgt;
   assign odd_operand = s.odd_idx;
   assign busy        = s.busy;
   assign done        = s.done;
   assign taken       = s.take;
   assign spec_exc    = s.spec_exc;
   assign addr_exc    = s.addr_exc;

   // Checks kept beside the logic they guard.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // Odd address found at fetch raises the exception next cycle.
   property p_odd_fetch;
      fetch_req && s.program_status_word.ia[0] |=> spec_exc && !addr_exc;
   endproperty
   a_odd_fetch: assert property (p_odd_fetch) else $error("odd fetch not flagged");

   // No fault pulse without a fetch.
   property p_no_branch_fault;
      !fetch_req |=> !spec_exc && !addr_exc;
   endproperty
   a_no_branch_fault: assert property (p_no_branch_fault) else $error("fault without fetch");

   // Fixed order of address, execution and replacement.
   property p_order;
      s.phase == bdu_pkg::PH_ADDR |=> s.phase == bdu_pkg::PH_EXEC ##1 s.phase == bdu_pkg::PH_REPL
         ##1 (s.phase == bdu_pkg::PH_IDLE && done);
   endproperty
   a_order: assert property (p_order) else $error("phase order broken");

   // Branch phases leave the condition code alone.
   property p_cc_kept;
      busy && !psw_load && !cc_set_en |=> $stable(s.program_status_word.cc);
   endproperty
   a_cc_kept: assert property (p_cc_kept) else $error("branch changed code");

   // Status load supplies the new code.
   property p_cc_load;
      psw_load |=> s.program_status_word.cc == $past(psw_new.cc);
   endproperty
   a_cc_load: assert property (p_cc_load) else $error("code not loaded");

   // Completion leaves target or updated address in the status word.
   property p_replace;
      done && !$past(psw_load) |-> s.program_status_word.ia == (s.take ? s.tgt : s.upd);
   endproperty
   a_replace: assert property (p_replace) else $error("wrong next address");

   // Conditional decision follows mask and code.
   property p_mask;
      s.phase == bdu_pkg::PH_EXEC && is_cond |-> s.take ==
         (s.req.first_register_field[2'h3 - $past(s.program_status_word.cc)] && !(is_rr && f2 == 4'h0));
   endproperty
   a_mask: assert property (p_mask) else $error("mask decision wrong");

   // Count register drops by exactly one.
   property p_count;
      s.phase == bdu_pkg::PH_EXEC && is_count |=> s.gpr[$past(f1)] == $past(s.gpr[f1]) - 32'h0000_0001;
   endproperty
   a_count: assert property (p_count) else $error("count not decremented");

   // Link word assembled from status fields.
   property p_link;
      s.phase == bdu_pkg::PH_EXEC && is_link |=> s.gpr[$past(f1)] ==
         {$past(ilc_eff), $past(s.program_status_word.cc), $past(s.program_status_word.pmask), $past(s.upd)};
   endproperty
   a_link: assert property (p_link) else $error("link word wrong");

   // Main scenarios.
   c_cond_taken: cover property (s.phase == bdu_pkg::PH_EXEC && is_cond && s.take);
   c_link_nobranch: cover property (done && !s.take && is_link);
   c_count_zero: cover property (done && is_count && !s.take);
   c_odd_fetch: cover property (spec_exc);
   c_link_exec: cover property (done && is_link && s.req.execute_subject_instr);

endmodule // bdu_top

// ===== sim/bdu_tb_top.sv
// Self-checking testbench of the branch decision unit.
`timescale 1ns/10ps
`include "bdu_defines.svh"

module bdu_tb_top;
   logic              clk, rstn, start, psw_load, cc_set_en, gr_wr_en, fetch_req; // Drive side.
   bdu_pkg::bdu_req_t req;                                     // Instruction under test.
   bdu_pkg::bdu_psw_t psw_new, program_status_word;                            // Status loaded and seen.
   logic [1:0]        cc_set_val;                              // Code from another operation.
   logic [3:0]        gr_wr_idx, gr_rd_idx, odd_operand;       // Register selects.
   logic [31:0]       gr_wr_data, gr_rd_data, rd;              // Register data.
   logic [23:0]       storage_top, target;                     // Storage limit and target.
   logic              busy, done, taken, spec_exc, addr_exc;   // Status outputs.
   int                n_fail = 0;                              // Mismatches.
   int                num_checks = 0;                          // Comparisons made.
   int                cycles = 0;                              // Watchdog count.

   bdu_top u_bdu_top (.clk, .rstn, .start, .req, .psw_load, .psw_new, .cc_set_en, .cc_set_val,
                      .gr_wr_en, .gr_wr_idx, .gr_wr_data, .gr_rd_idx, .fetch_req, .storage_top,
                      .gr_rd_data, .program_status_word, .target, .odd_operand, .busy, .done, .taken, .spec_exc,
                      .addr_exc);

   // Free-running 20 MHz clock.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Prints the verdict and stops the run.
   task automatic end_of_test;
      if (n_fail == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // A hang is cut short well beyond the two hundred or so cycles the run needs.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         end_of_test;
      end
   end

   // Compares one value; narrower values are zero-extended.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Inputs always change 5 ns after the rising edge, so no race with sampling.
   task automatic tick;
      @(posedge clk);
      #5;
   endtask

   // External register write, only legal while idle.
   task automatic wr(input logic [3:0] idx, input logic [31:0] data);
      gr_wr_en = 1'b1;
      gr_wr_idx = idx;
      gr_wr_data = data;
      tick;
      gr_wr_en = 1'b0;
      tick;
   endtask

   // Readback has one cycle of latency.
   task automatic rdchk(input logic [3:0] idx, input logic [31:0] exp);
      gr_rd_idx = idx;
      tick;
      chk("gpr", exp, gr_rd_data);
   endtask

   // Loads a whole status half with program mask 0xa.
   task automatic set_psw(input logic [1:0] cc, input logic [23:0] ia);
      psw_load = 1'b1;
      psw_new = '{2'h0, cc, 4'ha, ia};
      tick;
      psw_load = 1'b0;
   endtask

   // Issues one instruction, waits for completion and judges the outcome.
   task automatic run(input logic [7:0] op, input logic [3:0] f1, f2, b, input logic [11:0] d,
                      input logic ex, input logic [1:0] ilc, input logic tk, input logic [23:0] tgt);
      logic [23:0] ia0;
      logic [1:0]  cc0;
      int          i;
      ia0 = program_status_word.ia;
      cc0 = program_status_word.cc;
      req = '{op, f1, f2, b, d, ex, ilc};
      start = 1'b1;
      tick;
      start = 1'b0;
      chk("busy", 1, busy);
      for (i = 0; i < 8 && done !== 1'b1; i++) tick;
      chk("done", 1, done);
      chk("idle", 0, busy);
      chk("taken", tk, taken);
      chk("ia", tk ? tgt : ia0 + (ex ? 24'h4 : {21'h0, ilc, 1'b0}), program_status_word.ia);
      chk("cc", cc0, program_status_word.cc);
   endtask

   // Masks 0, 15, one bit and its complement against every code, plus the zero target field and indexed sums.
   task automatic t_cond;
      logic [3:0] m [4];
      wr(4'h3, 32'hab001234);
      for (int cc = 0; cc < 4; cc++) begin
         m = '{4'h0, 4'h8 >> cc, 4'hf, 4'hf ^ (4'h8 >> cc)};
         for (int k = 0; k < 4; k++) begin
            set_psw(cc[1:0], 24'h000100);
            run(`BDU_OP_COND_RR, m[k], 4'h3, 4'h0, 12'h0, 1'b0, 2'h1, m[k][3-cc], 24'h001234);
         end
      end
      run(`BDU_OP_COND_RR, 4'hf, 4'h0, 4'h0, 12'h0, 1'b0, 2'h1, 1'b0, 24'h0);
      // Register 0 holds junk so a zero field that reads it shows up.
      wr(4'h0, 32'h00000055);
      wr(4'h1, 32'h00fff000);
      wr(4'h2, 32'h00002000);
      run(`BDU_OP_COND_RX, 4'hf, 4'h1, 4'h2, 12'h010, 1'b0, 2'h2, 1'b1, 24'h001010);
      run(`BDU_OP_COND_RX, 4'hf, 4'h0, 4'h2, 12'h004, 1'b0, 2'h2, 1'b1, 24'h002004);
      run(`BDU_OP_COND_RX, 4'hf, 4'h1, 4'h0, 12'h002, 1'b0, 2'h2, 1'b1, 24'hfff002);
   endtask

   // Link words, same-register addressing, zero target field and execute subject.
   task automatic t_link;
      set_psw(2'h2, 24'h000200);
      wr(4'h3, 32'h00000400);
      run(`BDU_OP_LINK_RR, 4'h3, 4'h3, 4'h0, 12'h0, 1'b0, 2'h1, 1'b1, 24'h000400);
      rdchk(4'h3, {2'h1, 2'h2, 4'ha, 24'h000202});
      run(`BDU_OP_LINK_RR, 4'h5, 4'h0, 4'h0, 12'h0, 1'b0, 2'h1, 1'b0, 24'h0);
      rdchk(4'h5, {2'h1, 2'h2, 4'ha, 24'h000402});
      run(`BDU_OP_LINK_RX, 4'h6, 4'h0, 4'h0, 12'h300, 1'b1, 2'h2, 1'b1, 24'h000300);
      rdchk(4'h6, {2'h2, 2'h2, 4'ha, 24'h000406});
      rdchk(4'h3, {2'h1, 2'h2, 4'ha, 24'h000202});
   endtask

   // Count to zero, from zero, across the signed wrap and with no target.
   task automatic t_count;
      wr(4'h3, 32'h00000400);
      wr(4'h4, 32'h00000001);
      run(`BDU_OP_COUNT_RR, 4'h4, 4'h3, 4'h0, 12'h0, 1'b0, 2'h1, 1'b0, 24'h0);
      rdchk(4'h4, 32'h00000000);
      run(`BDU_OP_COUNT_RR, 4'h4, 4'h3, 4'h0, 12'h0, 1'b0, 2'h1, 1'b1, 24'h000400);
      rdchk(4'h4, 32'hffffffff);
      wr(4'h4, 32'h80000000);
      run(`BDU_OP_COUNT_RX, 4'h4, 4'h0, 4'h0, 12'h100, 1'b0, 2'h2, 1'b1, 24'h000100);
      rdchk(4'h4, 32'h7fffffff);
      run(`BDU_OP_COUNT_RR, 4'h4, 4'h0, 4'h0, 12'h0, 1'b0, 2'h1, 1'b0, 24'h0);
      rdchk(4'h4, 32'h7ffffffe);
   endtask

   // Storage-format target and the odd third-operand register.
   task automatic t_rs;
      run(`BDU_OP_IDX_HIGH, 4'h1, 4'h4, 4'h3, 12'h008, 1'b0, 2'h2, 1'b0, 24'h0);
      chk("target", 24'h000408, target);
      chk("odd", 4'h5, odd_operand);
      run(`BDU_OP_IDX_LOW, 4'h1, 4'h5, 4'h0, 12'h00c, 1'b0, 2'h2, 1'b0, 24'h0);
      chk("odd", 4'h5, odd_operand);
   endtask

   // Code written by other operations; a status load wins over it.
   task automatic t_cc;
      cc_set_en = 1'b1;
      cc_set_val = 2'h3;
      tick;
      cc_set_en = 1'b0;
      chk("cc", 2'h3, program_status_word.cc);
      tick;
      cc_set_en = 1'b1;
      cc_set_val = 2'h1;
      set_psw(2'h2, 24'h000100);
      cc_set_en = 1'b0;
      chk("cc", 2'h2, program_status_word.cc);
   endtask

   // One fetch check and the two exception pulses that follow it.
   task automatic fetch(input logic s, input logic a);
      fetch_req = 1'b1;
      tick;
      fetch_req = 1'b0;
      chk("spec", s, spec_exc);
      chk("addr", a, addr_exc);
   endtask

   // Main sequence: reset, then every scenario in turn.
   initial begin
      {rstn, start, psw_load, cc_set_en, gr_wr_en, fetch_req} = '0;
      {req, psw_new, cc_set_val, gr_wr_idx, gr_rd_idx, gr_wr_data} = '0;
      storage_top = 24'h000fff;
      repeat (10) @(posedge clk);
      #5;
      rstn = 1'b1;
      chk("psw", 32'h0, program_status_word);
      rdchk(4'h7, 32'h0);
      t_cond;
      t_link;
      t_count;
      t_rs;
      t_cc;
      set_psw(2'h0, 24'h000101);
      fetch(1'b1, 1'b0);
      set_psw(2'h0, 24'h001000);
      fetch(1'b0, 1'b1);
      // Last halfword of storage branches back into range: no fault.
      set_psw(2'h0, 24'h000ffe);
      wr(4'h3, 32'h00000400);
      run(`BDU_OP_COND_RR, 4'hf, 4'h3, 4'h0, 12'h0, 1'b0, 2'h1, 1'b1, 24'h000400);
      fetch(1'b0, 1'b0);
      end_of_test;
   end
endmodule // bdu_tb_top
